/* File: hw/osl_orientation_status.sv */
// Purpose: orientation status register, change flag and debounce of pose
// Assumes: raw pose, face and tilt inputs come from the angle classifier on i_clk
// Notes: i_sample marks one new sample; register reads are one-cycle strobes
module osl_orientation_status (
  input wire logic i_clk, // 25 MHz clock
  input wire logic i_nrst, // synchronous reset, active low
  input wire logic i_active, // 1 active mode, 0 standby
  input wire logic i_rate_change, // pulse: system sample rate changed
  input wire logic i_sample, // pulse: new sample and classification
  input wire logic [1:0] i_raw_pose, // classified pose of this sample
  input wire logic i_raw_face, // classified face of this sample
  input wire logic i_raw_tilt, // tilt lockout angle exceeded this sample
  input wire logic signed [13:0] i_acc_x, // x acceleration
  input wire logic signed [13:0] i_acc_y, // y acceleration
  input wire logic signed [13:0] i_acc_z, // z acceleration
  input wire logic [7:0] i_addr, // register address
  input wire logic i_wr, // write strobe
  input wire logic [7:0] i_wdata, // write data
  input wire logic i_rd, // read strobe
  output logic [7:0] o_rdata, // read data, registered
  output logic o_irq // change interrupt level
);
  logic [7:0] cfg;
  logic [7:0] db_count;
  logic [7:0] dbcnt;
  logic [1:0] pose;
  logic face;
  logic tilt;
  logic change;
  logic first_pending;
  logic active_q;
  logic [7:0] next_dbcnt;
  logic next_change;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire rd_status = i_rd && (i_addr == osl_pkg::ADDR_ORIENT_STATUS);
  wire wr_cfg = i_wr && (i_addr == osl_pkg::ADDR_ORIENT_CFG);
  wire wr_count = i_wr && (i_addr == osl_pkg::ADDR_DEBOUNCE_COUNT);
  wire enabled = cfg[osl_pkg::CFG_ENABLE_BIT] && i_active;
  wire mode_clear = cfg[osl_pkg::CFG_DBMODE_BIT];
  wire mode_edge = i_active != active_q;
  wire db_reset = mode_edge || i_rate_change;

  // ---------------------------------------------------------------
  // axis limit
  // ---------------------------------------------------------------
  wire [osl_pkg::AXIS_W-1:0] acc [3];
  wire [2:0] axis_over;
  assign acc[0] = i_acc_x;
  assign acc[1] = i_acc_y;
  assign acc[2] = i_acc_z;
  for (genvar g = 0; g < 3; g++) begin : g_axis
    // the most negative code folds onto itself, which still reads as above the limit
    wire [osl_pkg::AXIS_W-1:0] mag = acc[g][osl_pkg::AXIS_W-1] ? -acc[g] : acc[g];
    assign axis_over[g] = mag > osl_pkg::G_LIMIT;
  end
  wire over_g = |axis_over;

  // ---------------------------------------------------------------
  // change detect and debounce decision
  // ---------------------------------------------------------------
  wire differs = (i_raw_pose != pose) || (i_raw_face != face) || (i_raw_tilt != tilt);
  wire step = enabled && i_sample && !over_g;
  // count reaching the programmed value commits, also for a count of zero
  wire reach = (dbcnt + 8'h01 >= db_count) || (db_count == 8'h00);
  wire commit = step && (differs || first_pending) && reach;
  wire event_set = commit && (differs || first_pending);
  wire [7:0] status;
  assign status[osl_pkg::CHANGE_BIT] = change;
  assign status[osl_pkg::FREEZE_BIT] = tilt;
  assign status[osl_pkg::FREEZE_BIT-1:osl_pkg::POSE_LO+2] = '0;
  assign status[osl_pkg::POSE_LO+1:osl_pkg::POSE_LO] = pose;
  assign status[osl_pkg::FACE_BIT] = face;
  // only the two defined cfg bits read back, the rest read as zero
  wire [7:0] cfg_view = {cfg[osl_pkg::CFG_DBMODE_BIT], cfg[osl_pkg::CFG_ENABLE_BIT], 6'h00};

  // ---------------------------------------------------------------
  // debounce counter
  // ---------------------------------------------------------------
  always_comb begin
    next_dbcnt = dbcnt;
    if (db_reset || commit) begin
      next_dbcnt = 8'h00;
    end else if (step && (differs || first_pending)) begin
      next_dbcnt = (dbcnt == 8'hff) ? dbcnt : dbcnt + 8'h01;
    end else if (step) begin
      next_dbcnt = mode_clear ? 8'h00 : ((dbcnt == 8'h00) ? 8'h00 : dbcnt - 8'h01);
    end
  end

  // set beats the read clear so a coincident event survives
  always_comb begin
    next_change = change;
    if (rd_status) begin
      next_change = 1'b0;
    end
    if (event_set) begin
      next_change = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cfg <= osl_pkg::ORIENT_CFG_RESET;
      db_count <= osl_pkg::DEBOUNCE_COUNT_RESET;
      dbcnt <= 8'h00;
      pose <= osl_pkg::OSL_PORTRAIT_UP;
      face <= 1'b0;
      tilt <= 1'b0;
      change <= 1'b0;
      first_pending <= 1'b0;
      active_q <= 1'b0;
      o_rdata <= osl_pkg::ORIENT_STATUS_RESET;
      o_irq <= 1'b0;
    end else begin
      if (wr_cfg) begin
        cfg <= i_wdata;
      end
      if (wr_count) begin
        db_count <= i_wdata;
      end
      active_q <= i_active;
      dbcnt <= next_dbcnt;
      // armed on each standby to active edge, retired by the commit it forces
      if (i_active && !active_q) begin
        first_pending <= 1'b1;
      end else if (commit) begin
        first_pending <= 1'b0;
      end
      // fields keep tracking even with the change flag up
      if (commit) begin
        pose <= i_raw_pose;
        face <= i_raw_face;
        tilt <= i_raw_tilt;
      end
      change <= next_change;
      // registered copy of the flag so the interrupt pin never glitches
      o_irq <= next_change;
      if (i_rd) begin
        unique case (i_addr)
          osl_pkg::ADDR_ORIENT_STATUS: o_rdata <= status;
          osl_pkg::ADDR_ORIENT_CFG: o_rdata <= cfg_view;
          osl_pkg::ADDR_DEBOUNCE_COUNT: o_rdata <= db_count;
          default: o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_set_wins;
    @(posedge i_clk) disable iff (!i_nrst) (rd_status && event_set) |=> change;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("change lost on read");
  property p_read_clears;
    @(posedge i_clk) disable iff (!i_nrst) (rd_status && !event_set) |=> (!change && !o_irq);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear change");
  property p_hold_over_g;
    @(posedge i_clk) disable iff (!i_nrst) over_g |=> $stable(pose);
  endproperty
  a_hold_over_g: assert property (p_hold_over_g) else $error("pose moved above g limit");
  property p_disabled;
    @(posedge i_clk) disable iff (!i_nrst) !cfg[osl_pkg::CFG_ENABLE_BIT] |=> ($stable(pose) && $stable(face));
  endproperty
  a_disabled: assert property (p_disabled) else $error("detection ran while disabled");
  property p_change_sets;
    @(posedge i_clk) disable iff (!i_nrst) (commit && differs) |=> (change && o_irq);
  endproperty
  a_change_sets: assert property (p_change_sets) else $error("change flag not set");
  property p_db_reset;
    @(posedge i_clk) disable iff (!i_nrst) db_reset |=> (dbcnt == 8'h00);
  endproperty
  a_db_reset: assert property (p_db_reset) else $error("debounce not reset");
  property p_db_clear_mode;
    @(posedge i_clk) disable iff (!i_nrst) (step && !differs && !first_pending && mode_clear) |=> (dbcnt == 8'h00);
  endproperty
  a_db_clear_mode: assert property (p_db_clear_mode) else $error("clear mode failed");
  property p_no_early_commit;
    @(posedge i_clk) disable iff (!i_nrst) (step && differs && (dbcnt + 8'h01 < db_count)) |=>
      $stable(pose) && $stable(face) && $stable(tilt);
  endproperty
  a_no_early_commit: assert property (p_no_early_commit) else $error("committed before debounce");
  property p_first_after_active;
    @(posedge i_clk) disable iff (!i_nrst) (commit && first_pending) |=> change;
  endproperty
  a_first_after_active: assert property (p_first_after_active) else $error("first detection not flagged");
  property p_fields_follow;
    @(posedge i_clk) disable iff (!i_nrst) commit |=>
      (pose == $past(i_raw_pose)) && (face == $past(i_raw_face)) && (tilt == $past(i_raw_tilt));
  endproperty
  a_fields_follow: assert property (p_fields_follow) else $error("fields not taken from the sample");
  property p_track_while_set;
    @(posedge i_clk) disable iff (!i_nrst) (commit && change) |=> (pose == $past(i_raw_pose));
  endproperty
  a_track_while_set: assert property (p_track_while_set) else $error("pose frozen by change flag");
  property p_status_view;
    @(posedge i_clk) disable iff (!i_nrst) rd_status |=>
      (o_rdata[osl_pkg::CHANGE_BIT] == $past(change)) && (o_rdata[osl_pkg::FACE_BIT] == $past(face));
  endproperty
  a_status_view: assert property (p_status_view) else $error("status read does not show the flags");
  property p_quiet_holds;
    @(posedge i_clk) disable iff (!i_nrst) (!rd_status && !event_set) |=>
      (change == $past(change)) && (o_irq == change);
  endproperty
  a_quiet_holds: assert property (p_quiet_holds) else $error("change flag moved without cause");
  c_commit: cover property (@(posedge i_clk) disable iff (!i_nrst) commit && differs);
  c_coincide: cover property (@(posedge i_clk) disable iff (!i_nrst) rd_status && event_set);
  c_over_g: cover property (@(posedge i_clk) disable iff (!i_nrst) over_g && i_sample && enabled);
  c_first: cover property (@(posedge i_clk) disable iff (!i_nrst) commit && first_pending && !differs);
  c_decrement: cover property (@(posedge i_clk) disable iff (!i_nrst)
    step && !differs && !mode_clear && (dbcnt != 8'h00));
endmodule : osl_orientation_status

/* File: hw/osl_pkg.sv */
// Purpose: constants for the orientation status logic
// Assumes: 14-bit signed acceleration samples, 4096 counts per g (2 g range)
// Notes: register offsets are byte addresses on the register port
package osl_pkg;
  localparam logic [7:0] ADDR_ORIENT_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ORIENT_CFG = 8'h11;
  localparam logic [7:0] ADDR_DEBOUNCE_COUNT = 8'h12;
  localparam logic [7:0] ORIENT_STATUS_RESET = 8'h00;
  localparam logic [7:0] ORIENT_CFG_RESET = 8'h80;
  localparam logic [7:0] DEBOUNCE_COUNT_RESET = 8'h00;
  localparam int CHANGE_BIT = 7;
  localparam int FREEZE_BIT = 6;
  localparam int POSE_LO = 1;
  localparam int FACE_BIT = 0;
  localparam int CFG_DBMODE_BIT = 7;
  localparam int CFG_ENABLE_BIT = 6;
  localparam int AXIS_W = 14;
  // 1.25 g at 4096 counts per g
  localparam logic [AXIS_W-1:0] G_LIMIT = 14'h1400;
  typedef enum logic [1:0] {
    OSL_PORTRAIT_UP,
    OSL_PORTRAIT_DOWN,
    OSL_LANDSCAPE_RIGHT,
    OSL_LANDSCAPE_LEFT
  } osl_pose_t;
endpackage : osl_pkg

/* File: verif/osl_orientation_status_tb_top.sv */
// Purpose: self-checking bench for the orientation status logic
// Assumes: inputs move on the falling edge; strobes last one cycle
// Notes: acc values stay inside 1.25 g except in the freeze case
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module osl_orientation_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_nrst = 0, i_active = 0, i_rate_change = 0, i_sample = 0, i_raw_face = 0, i_raw_tilt = 0;
  logic i_wr = 0, i_rd = 0, o_irq, cf = 0, ct = 0, c;
  logic [1:0] i_raw_pose = 0, cp = 0, p;
  logic signed [13:0] i_acc_x = 0, i_acc_y = 0, i_acc_z = 0;
  logic [7:0] i_addr = 0, i_wdata = 0, o_rdata, q;
  logic [7:0] ra[4] = '{8'h10, 8'h11, 8'h12, 8'h20};
  logic [7:0] re[4] = '{osl_pkg::ORIENT_STATUS_RESET, osl_pkg::ORIENT_CFG_RESET, osl_pkg::DEBOUNCE_COUNT_RESET, 8'h00};
  int mismatches = 0, n_checks = 0, seed = 87804, cyc = 0;
  osl_orientation_status uut (.i_clk, .i_nrst, .i_active, .i_rate_change, .i_sample, .i_raw_pose, .i_raw_face,
    .i_raw_tilt, .i_acc_x, .i_acc_y, .i_acc_z, .i_addr, .i_wr, .i_wdata, .i_rd, .o_rdata, .o_irq);
  initial forever #20 i_clk = ~i_clk;
  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      results();
    end
  end
  task results;
    if (mismatches == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge i_clk); i_addr = a; i_wdata = d; i_wr = 1;
    @(negedge i_clk); i_wr = 0;
  endtask
  task rd(input logic [7:0] a);
    @(negedge i_clk); i_addr = a; i_rd = 1;
    @(negedge i_clk); i_rd = 0;
    @(negedge i_clk); q = o_rdata;
  endtask
  task smp(input logic [1:0] sp, input logic sf, st);
    @(negedge i_clk); i_raw_pose = sp; i_raw_face = sf; i_raw_tilt = st; i_sample = 1;
    @(negedge i_clk); i_sample = 0;
  endtask
  task rc;
    @(negedge i_clk); i_rate_change = 1;
    @(negedge i_clk); i_rate_change = 0;
  endtask
  function logic [7:0] exp_st(input logic ch);
    return {ch, ct, 3'h0, cp, cf};
  endfunction
  task ck(input logic ch);
    @(negedge i_clk);
    `CHK("irq", ch, o_irq)
    rd(8'h10);
    `CHK("status", exp_st(ch), q)
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(negedge i_clk);
    i_nrst = 1;
    for (int i = 0; i < 4; i++) begin
      rd(ra[i]);
      `CHK("reg reset", re[i], q)
    end
    wr(8'h11, 8'hc0);
    i_active = 1;
    smp(cp, cf, ct);
    ck(1);
    ck(0);
    for (int i = 0; i < 8; i++) begin
      p = 2'($random(seed));
      c = 1'($random(seed));
      i_acc_x = 14'($random(seed) % 5120);
      i_acc_z = 14'($random(seed) % 5120);
      smp(p, c, i[0]);
      c = (p != cp) || (c != cf) || (i[0] != ct);
      {cp, cf, ct} = {p, i_raw_face, i_raw_tilt};
      ck(c);
    end
    smp(cp + 2'h1, cf, ct);
    smp(cp + 2'h2, cf, ct);
    cp = cp + 2'h2;
    ck(1);
    i_acc_y = -14'sh1401;
    smp(cp + 2'h1, ~cf, ct);
    ck(0);
    i_acc_y = 14'sh1400;
    smp(cp + 2'h1, cf, ct);
    cp++;
    ck(1);
    wr(8'h11, 8'h80);
    smp(cp + 2'h1, cf, ct);
    ck(0);
    wr(8'h11, 8'hc0);
    @(negedge i_clk); i_addr = 8'h10; i_rd = 1; i_raw_pose = cp + 2'h1; i_sample = 1;
    @(negedge i_clk); i_rd = 0; i_sample = 0;
    `CHK("read before set", exp_st(0), o_rdata)
    cp++;
    ck(1);
    // ----------------------------------------
    // debounce: differ, differ, same, differ, differ with a count of 3
    // ----------------------------------------
    wr(8'h12, 8'h03);
    rd(8'h12);
    `CHK("debounce count", 8'h03, q)
    for (int m = 1; m >= 0; m--) begin
      wr(8'h11, {m[0], 7'h40});
      rc();
      for (int k = 0; k < 5; k++) smp((k == 2) ? cp : cp + 2'h1, cf, ct);
      if (m == 0) cp++;
      ck(m == 0);
    end
    rc();
    smp(cp + 2'h1, cf, ct);
    smp(cp + 2'h1, cf, ct);
    rc();
    smp(cp + 2'h1, cf, ct);
    smp(cp + 2'h1, cf, ct);
    ck(0);
    smp(cp + 2'h1, cf, ct);
    cp++;
    ck(1);
    // standby and back: counter restarts and the first detection is flagged
    smp(cp + 2'h1, cf, ct);
    smp(cp + 2'h1, cf, ct);
    @(negedge i_clk); i_active = 0;
    @(negedge i_clk); i_active = 1;
    smp(cp, cf, ct);
    smp(cp, cf, ct);
    ck(0);
    smp(cp, cf, ct);
    ck(1);
    // reset in mid-run
    @(negedge i_clk); i_nrst = 0;
    repeat (16) @(negedge i_clk);
    i_nrst = 1;
    `CHK("irq after reset", 1'b0, o_irq)
    rd(8'h10);
    `CHK("status after reset", osl_pkg::ORIENT_STATUS_RESET, q)
    results();
  end
endmodule // osl_orientation_status_tb_top
